/* core/prtm_defines.svh */
`ifndef PRTM_DEFINES_SVH
`define PRTM_DEFINES_SVH

// ******************************************
// register byte offsets on the apb bus
// ******************************************
`define PRTM_OFF_CTRL_ZERO 8'h00
`define PRTM_OFF_CTRL_ONE 8'h04
`define PRTM_OFF_COUNT 8'h08
`define PRTM_OFF_DUTY 8'h0C
`define PRTM_OFF_PERIOD 8'h10
`define PRTM_OFF_FLAGS 8'h14

// ******************************************
// field positions
// ******************************************
`define PRTM_C0_PAUSE 7
`define PRTM_C0_CLK_HI 6
`define PRTM_C0_CLK_LO 4
`define PRTM_C0_RUN 3
`define PRTM_C1_MODE_HI 7
`define PRTM_C1_MODE_LO 6
`define PRTM_C1_ACT_HI 5
`define PRTM_C1_ACT_LO 4
`define PRTM_C1_INIT 3
`define PRTM_C1_INV 2
`define PRTM_C1_CLRSEL 0
`define PRTM_FLAG_DUTY 0
`define PRTM_FLAG_PERIOD 1

// ******************************************
// reset values and counter limits
// ******************************************
`define PRTM_RST_CTRL_ZERO 8'h00
`define PRTM_RST_CTRL_ONE 8'h00
`define PRTM_RST_DATA 16'h0000
`define PRTM_CNT_MAX 16'hFFFF

// ******************************************
// prescaler masks for the divided clocks
// ******************************************
`define PRTM_DIV4_MASK 6'h03
`define PRTM_DIV16_MASK 6'h0F
`define PRTM_DIV64_MASK 6'h3F

`endif

/* core/prtm_pkg.sv */
package prtm_pkg;

  // operating mode codes
  typedef enum logic [1:0] {
    PRTM_MODE_CMP = 2'h0,
    PRTM_MODE_UNDEF = 2'h1,
    PRTM_MODE_PWM = 2'h2,
    PRTM_MODE_TC = 2'h3
  } prtm_mode_t;

  // output action codes in pwm / single pulse mode
  typedef enum logic [1:0] {
    PRTM_ACT_INACTIVE = 2'h0,
    PRTM_ACT_ACTIVE = 2'h1,
    PRTM_ACT_PWM = 2'h2,
    PRTM_ACT_SINGLE = 2'h3
  } prtm_act_t;

  // counter clock source codes
  typedef enum logic [2:0] {
    PRTM_CLK_SYS_DIV4 = 3'h0,
    PRTM_CLK_SYS = 3'h1,
    PRTM_CLK_HIGH_DIV16 = 3'h2,
    PRTM_CLK_HIGH_DIV64 = 3'h3,
    PRTM_CLK_SUB_A = 3'h4,
    PRTM_CLK_SUB_B = 3'h5,
    PRTM_CLK_EXT_RISE = 3'h6,
    PRTM_CLK_EXT_FALL = 3'h7
  } prtm_clksel_t;

endpackage

/* core/prtm_clk_sel.sv */
`include "prtm_defines.svh"

module prtm_clk_sel
  import prtm_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [2:0] count_clock_select,
  input wire logic external_count_clock_pin,
  input wire logic sub_clock,
  output logic count_tick
);

  logic [1:0] ext_sync_reg;
  logic [1:0] sub_sync_reg;
  logic ext_last_reg;
  logic sub_last_reg;
  logic [5:0] prescale_reg;
  prtm_clksel_t sel;

  assign sel = prtm_clksel_t'(count_clock_select);

  // ******************************************
  // pin synchronisers and edge history
  // ******************************************
  // the first stage feeds only the second; edges are taken after stage two
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ext_sync_reg <= 2'h0;
      sub_sync_reg <= 2'h0;
      ext_last_reg <= 1'b0;
      sub_last_reg <= 1'b0;
    end else begin
      ext_sync_reg <= {ext_sync_reg[0], external_count_clock_pin};
      sub_sync_reg <= {sub_sync_reg[0], sub_clock};
      ext_last_reg <= ext_sync_reg[1];
      sub_last_reg <= sub_sync_reg[1];
    end
  end

  // free running prescaler; the high speed clock is taken as the system clock
  always_ff @(posedge core_clk) begin
    if (reset) begin
      prescale_reg <= 6'h00;
    end else begin
      prescale_reg <= prescale_reg + 6'h01;
    end
  end

  // ******************************************
  // source selection
  // ******************************************
  // clock source select
  always_comb begin
    unique case (sel)
      PRTM_CLK_SYS_DIV4: count_tick = (prescale_reg & `PRTM_DIV4_MASK) == `PRTM_DIV4_MASK;
      PRTM_CLK_SYS: count_tick = 1'b1;
      PRTM_CLK_HIGH_DIV16: count_tick = (prescale_reg & `PRTM_DIV16_MASK) == `PRTM_DIV16_MASK;
      PRTM_CLK_HIGH_DIV64: count_tick = prescale_reg == `PRTM_DIV64_MASK;
      PRTM_CLK_SUB_A,
      PRTM_CLK_SUB_B: count_tick = sub_sync_reg[1] & ~sub_last_reg;
      PRTM_CLK_EXT_RISE: count_tick = ext_sync_reg[1] & ~ext_last_reg;
      PRTM_CLK_EXT_FALL: count_tick = ~ext_sync_reg[1] & ext_last_reg;
    endcase
  end

endmodule

/* core/prtm_core.sv */
// Summary of operation
// - three-bit field picks counter clock: sys/4, sys, high/16, high/64, sub, pin edges
// - run rising clears and starts the counter; run low stops it, value kept
// - run rising returns the output to its initial level in compare mode
// - mode field: 00 compare, 01 undefined, 10 pwm/single pulse, 11 timer
// - pwm mode action: 00 inactive, 01 active, 10 pwm, 11 single pulse
// - requested level equal to initial level means no pin change on match
// - initial level bit gives start level, or active level in pwm modes
// - invert bit inverts the output pin, except in timer mode
// - clear select 1: duty match clears; 0: period match or overflow clears
// - overflow clearing only when the period value is all zeros
// - clear select is ignored in pwm and single pulse modes
// - clear select 0 in compare mode raises both match flags
// - clear select 1 in compare or timer mode raises only the duty flag, never the period flag
// - zero duty value: counter overflows at its maximum, no duty flag
// - in compare mode only duty matches change the pin
// - timer mode counts and flags like compare mode but leaves the pin
// - pwm: period match clears counter, duty sets duty, each raises its flag
// - pause freezes the counter while powered; release resumes from there
// - sixteen-bit up counter; comparators check all counter bits
// - pwm duty at or above period gives full duty; zero period is full range
`include "prtm_defines.svh"

module prtm_core
  import prtm_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_count_clock_pin,
  input wire logic sub_clock,
  output logic timer_output_pin,
  output logic timer_output_pin_oe
);

  // ******************************************
  // state and decoded fields
  // ******************************************
  logic counter_pause_reg;
  logic counter_run_enable_reg;
  logic [2:0] count_clock_select_reg;
  logic [7:0] timer_control_one_reg;
  logic [15:0] cnt_reg;
  logic [15:0] duty_compare_value_reg;
  logic [15:0] period_compare_value_reg;
  logic duty_match_flag_reg;
  logic period_match_flag_reg;
  logic run_prev_reg;
  logic out_level_reg;
  logic pin_reg;
  logic oe_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic [31:0] rdata_next;
  logic addr_hit;
  logic count_tick;
  prtm_mode_t mode;
  prtm_act_t action;
  logic init_level;
  logic invert;
  logic clear_sel;
  logic is_pwm;
  logic is_single;
  logic run_start;
  logic advance;
  logic duty_hit;
  logic period_hit;
  logic clear_hit;
  logic duty_set;
  logic period_set;
  logic pwm_on;
  logic level_next;
  logic wr_en;
  logic setup;

  assign mode = prtm_mode_t'(timer_control_one_reg[`PRTM_C1_MODE_HI:`PRTM_C1_MODE_LO]);
  assign action = prtm_act_t'(timer_control_one_reg[`PRTM_C1_ACT_HI:`PRTM_C1_ACT_LO]);
  assign init_level = timer_control_one_reg[`PRTM_C1_INIT];
  assign invert = timer_control_one_reg[`PRTM_C1_INV];
  assign clear_sel = timer_control_one_reg[`PRTM_C1_CLRSEL];
  assign is_pwm = mode == PRTM_MODE_PWM;
  assign is_single = is_pwm && action == PRTM_ACT_SINGLE;

  prtm_clk_sel u_clk_sel (
    .core_clk(core_clk),
    .reset(reset),
    .count_clock_select(count_clock_select_reg),
    .external_count_clock_pin(external_count_clock_pin),
    .sub_clock(sub_clock),
    .count_tick(count_tick)
  );

  // ******************************************
  // apb slave
  // ******************************************
  // zero wait states: read data is latched in the setup cycle
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite;
  assign pready = 1'b1;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;

  // read mux; unused upper bits read as zero
  always_comb begin
    addr_hit = 1'b1;
    rdata_next = 32'h0000_0000;
    unique case (paddr)
      `PRTM_OFF_CTRL_ZERO: rdata_next[7:0] = {counter_pause_reg, count_clock_select_reg,
                                              counter_run_enable_reg, 3'h0};
      `PRTM_OFF_CTRL_ONE: rdata_next[7:0] = timer_control_one_reg;
      `PRTM_OFF_COUNT: rdata_next[15:0] = cnt_reg;
      `PRTM_OFF_DUTY: rdata_next[15:0] = duty_compare_value_reg;
      `PRTM_OFF_PERIOD: rdata_next[15:0] = period_compare_value_reg;
      `PRTM_OFF_FLAGS: rdata_next[1:0] = {period_match_flag_reg, duty_match_flag_reg};
      default: addr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (setup) begin
      prdata_reg <= pwrite ? 32'h0000_0000 : rdata_next;
      pslverr_reg <= ~addr_hit;
    end
  end

  // configuration registers; a write to unmapped space is dropped
  always_ff @(posedge core_clk) begin
    if (reset) begin
      counter_pause_reg <= 1'(`PRTM_RST_CTRL_ZERO >> `PRTM_C0_PAUSE);
      count_clock_select_reg <= 3'h0;
      timer_control_one_reg <= `PRTM_RST_CTRL_ONE;
      duty_compare_value_reg <= `PRTM_RST_DATA;
      period_compare_value_reg <= `PRTM_RST_DATA;
    end else if (wr_en) begin
      if (paddr == `PRTM_OFF_CTRL_ZERO) begin
        counter_pause_reg <= pwdata[`PRTM_C0_PAUSE];
        count_clock_select_reg <= pwdata[`PRTM_C0_CLK_HI:`PRTM_C0_CLK_LO];
      end
      if (paddr == `PRTM_OFF_CTRL_ONE) begin
        timer_control_one_reg <= pwdata[7:0];
      end
      if (paddr == `PRTM_OFF_DUTY) begin
        duty_compare_value_reg <= pwdata[15:0];
      end
      if (paddr == `PRTM_OFF_PERIOD) begin
        period_compare_value_reg <= pwdata[15:0];
      end
    end
  end

  // ******************************************
  // run control
  // ******************************************
  // single pulse ends on duty match
  // a software write in the same cycle wins so a restart is never lost
  always_ff @(posedge core_clk) begin
    if (reset) begin
      counter_run_enable_reg <= 1'b0;
    end else if (wr_en && paddr == `PRTM_OFF_CTRL_ZERO) begin
      counter_run_enable_reg <= pwdata[`PRTM_C0_RUN];
    end else if (is_single && duty_hit) begin
      counter_run_enable_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      run_prev_reg <= 1'b0;
    end else begin
      run_prev_reg <= counter_run_enable_reg;
    end
  end

  assign run_start = counter_run_enable_reg & ~run_prev_reg;
  assign advance = counter_run_enable_reg & ~counter_pause_reg & count_tick & ~run_start;

  // ******************************************
  // comparators and counter clearing
  // ******************************************
  // full width compare
  assign duty_hit = advance && duty_compare_value_reg != 16'h0000 && cnt_reg == duty_compare_value_reg;
  assign period_hit = advance && (period_compare_value_reg == 16'h0000 ? cnt_reg == `PRTM_CNT_MAX
                                                                       : cnt_reg == period_compare_value_reg);

  // pwm and single pulse ignore it
  always_comb begin
    if (is_single) begin
      clear_hit = 1'b0;
    end else if (is_pwm) begin
      clear_hit = period_hit;
    end else begin
      clear_hit = clear_sel ? duty_hit : period_hit;
    end
  end

  // run rise clears, stop keeps value
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cnt_reg <= `PRTM_RST_DATA;
    end else if (run_start) begin
      cnt_reg <= 16'h0000;
    end else if (advance) begin
      cnt_reg <= clear_hit ? 16'h0000 : cnt_reg + 16'h0001;
    end
  end

  // ******************************************
  // match flags
  // ******************************************
  // both flags with clear select 0, except in single pulse
  // no period flag with clear select 1 in compare and timer modes
  assign duty_set = duty_hit;
  assign period_set = period_hit && !is_single && (is_pwm || !clear_sel);

  // sticky flags, write one to clear, set wins
  always_ff @(posedge core_clk) begin
    if (reset) begin
      duty_match_flag_reg <= 1'b0;
      period_match_flag_reg <= 1'b0;
    end else begin
      duty_match_flag_reg <= duty_set | (duty_match_flag_reg &
        ~(wr_en && paddr == `PRTM_OFF_FLAGS && pwdata[`PRTM_FLAG_DUTY]));
      period_match_flag_reg <= period_set | (period_match_flag_reg &
        ~(wr_en && paddr == `PRTM_OFF_FLAGS && pwdata[`PRTM_FLAG_PERIOD]));
    end
  end

  // ******************************************
  // output waveform
  // ******************************************
  // run rise restores initial level
  // compare action; same level gives no change; duty only
  always_ff @(posedge core_clk) begin
    if (reset) begin
      out_level_reg <= 1'b0;
    end else if (run_start) begin
      out_level_reg <= init_level;
    end else if (duty_hit && mode == PRTM_MODE_CMP) begin
      unique case (timer_control_one_reg[`PRTM_C1_ACT_HI:`PRTM_C1_ACT_LO])
        2'h0: out_level_reg <= out_level_reg;
        2'h1: out_level_reg <= 1'b0;
        2'h2: out_level_reg <= 1'b1;
        2'h3: out_level_reg <= ~out_level_reg;
      endcase
    end
  end

  // duty at or above period is full duty
  assign pwm_on = (period_compare_value_reg != 16'h0000 && duty_compare_value_reg >= period_compare_value_reg)
                  || cnt_reg < duty_compare_value_reg;

  // initial level doubles as the active level in pwm modes
  always_comb begin
    if (is_pwm) begin
      unique case (action)
        PRTM_ACT_INACTIVE: level_next = ~init_level;
        PRTM_ACT_ACTIVE: level_next = init_level;
        PRTM_ACT_PWM: level_next = pwm_on ? init_level : ~init_level;
        PRTM_ACT_SINGLE: level_next = counter_run_enable_reg ? init_level : ~init_level;
      endcase
    end else begin
      level_next = out_level_reg;
    end
  end

  // timer mode releases the pin; mode decode
  // the pin lags the level by one cycle to keep it glitch free
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pin_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      pin_reg <= (mode == PRTM_MODE_TC) ? 1'b0 : level_next ^ invert;
      oe_reg <= mode != PRTM_MODE_TC;
    end
  end

  assign timer_output_pin = pin_reg;
  assign timer_output_pin_oe = oe_reg;

  // ******************************************
  // assertions
  // ******************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_run_rise_clear: assert property (run_start |=> cnt_reg == 16'h0000)
    else $error("counter not cleared on run rise");
  a_stop_holds: assert property (!counter_run_enable_reg |=> $stable(cnt_reg))
    else $error("counter moved while stopped");
  a_pause_freeze: assert property (counter_pause_reg && !run_start |=> $stable(cnt_reg))
    else $error("counter moved while paused");
  a_init_restore: assert property (run_start && mode == PRTM_MODE_CMP |=> out_level_reg == $past(init_level))
    else $error("output not restored to initial level");
  a_no_period_flag: assert property (mode == PRTM_MODE_CMP && clear_sel && !period_match_flag_reg
                                     ##1 !(wr_en && paddr == `PRTM_OFF_CTRL_ONE) |-> !period_match_flag_reg)
    else $error("period flag raised with duty clear");
  a_zero_duty_flag: assert property (duty_compare_value_reg == 16'h0000 && !duty_match_flag_reg
                                     |=> !duty_match_flag_reg)
    else $error("duty flag with zero duty value");
  a_flag_sticky: assert property (duty_match_flag_reg && !(wr_en && paddr == `PRTM_OFF_FLAGS)
                                  |=> duty_match_flag_reg)
    else $error("duty flag dropped without clear");
  a_tc_release: assert property (mode == PRTM_MODE_TC ##1 mode == PRTM_MODE_TC |-> !timer_output_pin_oe)
    else $error("pin driven in timer mode");
  // forced active level seen at the pin, independent of the level mux
  a_pin_invert: assert property (is_pwm && action == PRTM_ACT_ACTIVE
                                 |=> timer_output_pin == ($past(init_level) ^ $past(invert)))
    else $error("pin level does not follow invert");
  a_pulse_end: assert property (is_single && duty_hit && !wr_en ##1 1'b1 |-> !counter_run_enable_reg)
    else $error("single pulse did not stop");
  a_period_clear: assert property (is_pwm && !is_single && period_hit |=> cnt_reg == 16'h0000)
    else $error("pwm period match did not clear");

  c_pwm_period: cover property (is_pwm && period_set);
  c_cmp_toggle: cover property (mode == PRTM_MODE_CMP && duty_hit && action == PRTM_ACT_SINGLE);
  c_pulse_done: cover property (is_single && duty_hit);
  c_overflow: cover property (period_hit && period_compare_value_reg == 16'h0000);

endmodule

/* sim/prtm_pin_model.sv */
module prtm_pin_model (
  input wire logic core_clk,
  output logic external_count_clock_pin,
  output logic sub_clock
);
  timeunit 1ns;
  timeprecision 1ps;

  int sub_cnt = 0;

  // both pins start low; the count pin idles low between pulses
  initial begin
    external_count_clock_pin = 1'b0;
    sub_clock = 1'b0;
  end

  // the slow clock runs free, one rising edge every 40 core cycles
  // sub clock source
  always @(posedge core_clk) begin
    sub_cnt <= (sub_cnt == 19) ? 0 : sub_cnt + 1;
    if (sub_cnt == 19) begin
      sub_clock <= ~sub_clock;
    end
  end

  // each level held at least 6 cycles so the two-stage synchroniser sees every edge
  // pin edge sources
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge core_clk);
      external_count_clock_pin <= 1'b1;
      repeat (6) @(posedge core_clk);
      external_count_clock_pin <= 1'b0;
      repeat (6) @(posedge core_clk);
    end
  endtask
endmodule

/* sim/periodic_timer_module_tb_top.sv */
`include "prtm_defines.svh"

module periodic_timer_module_tb_top
  import prtm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ******************************************
  // signals and bookkeeping
  // ******************************************
  typedef struct {logic is_rd; logic [31:0] lo; logic [31:0] hi; logic err;} prtm_note_t;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, hi_cnt;
  logic pready, pslverr, pin, pin_oe, ext_pin, sub_clk;
  int fail_count = 0, checks = 0, code, k;
  int divs[6] = '{4, 1, 16, 64, 40, 40};
  logic [6:0] cmp_rows[7] = '{7'b00_1_0_1_1_1, 7'b01_0_0_0_0_0, 7'b01_1_0_1_0_0, 7'b10_0_0_0_1_1,
    7'b10_1_0_1_1_1, 7'b11_0_0_0_1_0, 7'b10_0_1_1_0_0};
  logic [7:0] pwm_rows[6] = '{8'hA3, 8'h83, 8'hB3, 8'hA8, 8'h23, 8'h63};
  int pwm_exp[6] = '{30, 50, 50, 80, 0, 80};
  prtm_note_t notes[$];
  prtm_note_t cur;

  always #5 core_clk = ~core_clk;

  prtm_core uut (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_count_clock_pin(ext_pin), .sub_clock(sub_clk), .timer_output_pin(pin),
    .timer_output_pin_oe(pin_oe));
  prtm_pin_model pins (.core_clk(core_clk), .external_count_clock_pin(ext_pin), .sub_clock(sub_clk));

  // ******************************************
  // tasks
  // ******************************************
  task automatic summarize();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask

  // one apb transfer; the note is queued before the request goes out
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] lo,
    input logic [31:0] hi, input logic err);
    int n;
    n = 0;
    notes.push_back('{is_rd: !wr, lo: lo, hi: hi, err: err});
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      fail_count++;
      summarize();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
    apb(1'b0, a, 32'h0, lo, hi, 1'b0);
  endtask

  // the extra step lets the edge's register updates land before sampling
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  function automatic logic [31:0] c0(input logic p, input logic [2:0] ck, input logic run);
    return {24'h0, p, ck, run, 3'h0};
  endfunction

  function automatic logic [31:0] c1(input logic [1:0] m, input logic [1:0] act, input logic oc,
    input logic inv, input logic clr);
    return {24'h0, m, act, oc, inv, 1'b0, clr};
  endfunction

  // completed transfers are matched against the oldest note; reads may allow a range
  always @(posedge core_clk) begin
    if (psel && penable && pready === 1'b1 && notes.size() > 0) begin
      cur = notes.pop_front();
      checks++;
      if (pslverr !== cur.err || (cur.is_rd && !((prdata >= cur.lo) === 1'b1 && (prdata <= cur.hi) === 1'b1))) begin
        fail_count++;
        $display("[FAIL] apb %0h expected %0h..%0h err %b seen %0h err %b", paddr, cur.lo, cur.hi, cur.err,
          prdata, pslverr);
      end
    end
  end

  // ******************************************
  // main sequence
  // ******************************************
  initial begin
    void'($urandom(87961));
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    // reset values, read/write storage and the refused unmapped word
    for (k = 0; k < 6; k++) begin
      rd(8'(4 * k), 32'h0, 32'h0);
    end
    apb(1'b1, 8'h18, 32'hFFFF, 32'h0, 32'h0, 1'b1);
    apb(1'b0, 8'h18, 32'h0, 32'h0, 32'h0, 1'b1);
    wr(`PRTM_OFF_CTRL_ONE, c1(2'h3, 2'h2, 1'b1, 1'b1, 1'b1));
    rd(`PRTM_OFF_CTRL_ONE, 32'h00ED, 32'h00ED);
    wr(`PRTM_OFF_CTRL_ONE, 32'h0);
    wr(`PRTM_OFF_DUTY, 32'h0100);
    // pin edges give exact counts: run, pause, resume, stop, restart
    for (code = 6; code < 8; code++) begin
      k = $urandom_range(4, 1);
      wr(`PRTM_OFF_CTRL_ZERO, c0(1'b0, 3'(code), 1'b1));
      pins.pulse(k);
      wt(6);
      rd(`PRTM_OFF_COUNT, 32'(k), 32'(k));
      wr(`PRTM_OFF_CTRL_ZERO, c0(1'b1, 3'(code), 1'b1));
      pins.pulse(2);
      wt(6);
      rd(`PRTM_OFF_COUNT, 32'(k), 32'(k));
      wr(`PRTM_OFF_CTRL_ZERO, c0(1'b0, 3'(code), 1'b1));
      pins.pulse(2);
      wt(6);
      rd(`PRTM_OFF_COUNT, 32'(k + 2), 32'(k + 2));
      wr(`PRTM_OFF_CTRL_ZERO, c0(1'b0, 3'(code), 1'b0));
      pins.pulse(2);
      wt(6);
      rd(`PRTM_OFF_COUNT, 32'(k + 2), 32'(k + 2));
      wr(`PRTM_OFF_CTRL_ZERO, c0(1'b1, 3'(code), 1'b1));
      rd(`PRTM_OFF_COUNT, 32'h0, 32'h0);
      wr(`PRTM_OFF_CTRL_ZERO, c0(1'b0, 3'(code), 1'b0));
    end
    // internal rates over a 130 cycle run, a little slack for phase
    for (code = 0; code < 6; code++) begin
      wr(`PRTM_OFF_CTRL_ZERO, c0(1'b0, 3'(code), 1'b1));
      wt(128);
      wr(`PRTM_OFF_CTRL_ZERO, c0(1'b0, 3'(code), 1'b0));
      rd(`PRTM_OFF_COUNT, 32'(130 / divs[code] - 2), 32'(130 / divs[code] + 2));
    end
    // compare mode, duty match clears, period below duty
    wr(`PRTM_OFF_DUTY, 32'h0028);
    wr(`PRTM_OFF_PERIOD, 32'h0003);
    for (k = 0; k < 7; k++) begin
      wr(`PRTM_OFF_CTRL_ONE, c1(2'h0, cmp_rows[k][6:5], cmp_rows[k][4], cmp_rows[k][3], 1'b1));
      wr(`PRTM_OFF_CTRL_ZERO, c0(1'b0, 3'h1, 1'b1));
      wt(20);
      chk("pin before match", cmp_rows[k][2], pin);
      wt(40);
      chk("pin after match", cmp_rows[k][1], pin);
      wt(40);
      chk("pin after second match", cmp_rows[k][0], pin);
      wr(`PRTM_OFF_CTRL_ZERO, c0(1'b0, 3'h1, 1'b0));
      rd(`PRTM_OFF_FLAGS, 32'h1, 32'h1);
      wr(`PRTM_OFF_FLAGS, 32'h3);
      rd(`PRTM_OFF_FLAGS, 32'h0, 32'h0);
    end
    // compare mode, period match clears; only duty matches move the pin
    wr(`PRTM_OFF_DUTY, 32'h000A);
    wr(`PRTM_OFF_PERIOD, 32'h0014);
    wr(`PRTM_OFF_CTRL_ONE, c1(2'h0, 2'h3, 1'b0, 1'b0, 1'b0));
    wr(`PRTM_OFF_CTRL_ZERO, c0(1'b0, 3'h1, 1'b1));
    wt(15);
    chk("pin first toggle", 1'b1, pin);
    chk("pin driven", 1'b1, pin_oe);
    wt(12);
    chk("pin at period match", 1'b1, pin);
    wt(11);
    chk("pin second toggle", 1'b0, pin);
    wr(`PRTM_OFF_CTRL_ZERO, c0(1'b1, 3'h1, 1'b1));
    rd(`PRTM_OFF_COUNT, 32'h0, 32'h0014);
    rd(`PRTM_OFF_FLAGS, 32'h3, 32'h3);
    wr(`PRTM_OFF_CTRL_ZERO, c0(1'b0, 3'h1, 1'b0));
    wr(`PRTM_OFF_FLAGS, 32'h3);
    wr(`PRTM_OFF_CTRL_ONE, c1(2'h3, 2'h3, 1'b0, 1'b0, 1'b0));
    wr(`PRTM_OFF_CTRL_ZERO, c0(1'b0, 3'h1, 1'b1));
    wt(40);
    chk("pin released in timer mode", 1'b0, pin_oe);
    rd(`PRTM_OFF_FLAGS, 32'h3, 32'h3);
    // pwm: high cycles over an 80 cycle window, period value eight
    wr(`PRTM_OFF_PERIOD, 32'h0008);
    for (k = 0; k < 6; k++) begin
      wr(`PRTM_OFF_CTRL_ZERO, c0(1'b0, 3'h1, 1'b0));
      // old flags cleared so the pwm flag read below is earned here
      wr(`PRTM_OFF_FLAGS, 32'h3);
      wr(`PRTM_OFF_DUTY, {28'h0, pwm_rows[k][3:0]});
      wr(`PRTM_OFF_CTRL_ONE, c1(2'h2, pwm_rows[k][7:6], pwm_rows[k][5], pwm_rows[k][4], 1'b1));
      wr(`PRTM_OFF_CTRL_ZERO, c0(1'b0, 3'h1, 1'b1));
      wt(6);
      hi_cnt = 32'h0;
      repeat (80) begin
        wt(1);
        hi_cnt = hi_cnt + pin;
      end
      chk("pwm high cycles", 1'b1, hi_cnt + 4 >= pwm_exp[k] && hi_cnt <= pwm_exp[k] + 4);
    end
    rd(`PRTM_OFF_FLAGS, 32'h3, 32'h3);
    // single pulse: active at start, duty match ends it and clears run
    wr(`PRTM_OFF_CTRL_ZERO, c0(1'b0, 3'h1, 1'b0));
    wr(`PRTM_OFF_DUTY, 32'h0014);
    wr(`PRTM_OFF_CTRL_ONE, c1(2'h2, 2'h3, 1'b1, 1'b0, 1'b0));
    wr(`PRTM_OFF_CTRL_ZERO, c0(1'b0, 3'h1, 1'b1));
    wt(5);
    chk("single pulse active", 1'b1, pin);
    wt(35);
    chk("single pulse ended", 1'b0, pin);
    rd(`PRTM_OFF_CTRL_ZERO, c0(1'b0, 3'h1, 1'b0), c0(1'b0, 3'h1, 1'b0));
    // zero duty and period: full 16-bit wrap, period flag only
    // zero duty is only set in timer mode, never in compare mode
    wr(`PRTM_OFF_CTRL_ONE, c1(2'h3, 2'h0, 1'b0, 1'b0, 1'b0));
    wr(`PRTM_OFF_DUTY, 32'h0);
    wr(`PRTM_OFF_PERIOD, 32'h0);
    wr(`PRTM_OFF_FLAGS, 32'h3);
    wr(`PRTM_OFF_CTRL_ZERO, c0(1'b0, 3'h1, 1'b1));
    wt(65560);
    rd(`PRTM_OFF_FLAGS, 32'h2, 32'h2);
    summarize();
  end
endmodule
